// *** rtl/pirfb_flag_bank.sv ***
// Purpose: Eight-bit peripheral interrupt flag bank with enables and request
// Assumes: Inputs synchronous to i_clk; strobes one cycle, never both at once
// Notes:   Read data valid the cycle after the read strobe
//
// Added by the designer: strobed register access and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module pirfb_flag_bank
    import pirfb_pkg::*;
(
    input  wire logic                          i_clk,           // System clock
    input  wire logic                          i_arst_n,        // Async reset, active low
    input  wire logic [pirfb_pkg::ADDR_W-1:0]  i_addr,          // Register address
    input  wire logic [pirfb_pkg::DATA_W-1:0]  i_wdata,         // Write data
    input  wire logic                          i_wr,            // Write strobe
    input  wire logic                          i_rd,            // Read strobe
    output var  logic [pirfb_pkg::DATA_W-1:0]  o_rdata,         // Read data, cycle after
    input  wire logic                          i_nvm_done,      // Memory write done pulse
    input  wire logic                          i_conv_done,     // Conversion done pulse
    input  wire logic                          i_rx_full,       // Receive buffer full level
    input  wire logic                          i_tx_empty,      // Transmit buffer empty level
    input  wire logic                          i_cmp_b_output,  // Comparator B output
    input  wire logic                          i_cmp_a_output,  // Comparator A output
    input  wire logic                          i_osc_fail,      // Switched to internal osc pulse
    input  wire logic                          i_timer_b_ovf,   // Timer overflow pulse
    output var  logic                          o_irq            // Peripheral interrupt request
);
    import pirfb_pkg::*;

    logic [7:0] flags;
    logic [7:0] sticky_q;
    logic       rx_full_q;
    logic       tx_empty_q;
    logic [7:0] peripheral_irq_enables;
    logic       global_irq_enable;
    logic       peripheral_group_enable;
    logic       cmp_a_prev;
    logic       cmp_b_prev;
    logic [7:0] set_vec;
    logic [7:0] clr_vec;
    logic       wr_flags;
    logic       next_irq;

    assign wr_flags = i_wr && (i_addr == OFS_FLAGS);

    // Comparator history for change detection
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cmp_a_prev <= 1'b0;
            cmp_b_prev <= 1'b0;
        end else begin
            cmp_a_prev <= i_cmp_a_output;
            cmp_b_prev <= i_cmp_b_output;
        end
    end

    // Event vector, independent of any enable
    // ungated event sets
    always_comb begin
        set_vec = 8'h00;
        set_vec[BIT_NVM_DONE]  = i_nvm_done;
        set_vec[BIT_CONV_DONE] = i_conv_done;
        set_vec[BIT_CMP_B]     = i_cmp_b_output ^ cmp_b_prev;
        set_vec[BIT_CMP_A]     = i_cmp_a_output ^ cmp_a_prev;
        set_vec[BIT_OSC_FAIL]  = i_osc_fail;
        set_vec[BIT_TIMER_B]   = i_timer_b_ovf;
    end

    // Software writes zero to clear writable flags
    // only writable bits clear
    assign clr_vec = wr_flags ? (~i_wdata & FLAGS_WR_MASK) : 8'h00;

    // Sticky flags on the six writable positions
    for (genvar g = 0; g < 8; g++) begin : g_sticky
        if (FLAGS_WR_MASK[g]) begin : g_on
            pirfb_sticky_flag u_flag (
                .i_clk    (i_clk),
                .i_arst_n (i_arst_n),
                .i_set    (set_vec[g]),
                .i_clr    (clr_vec[g]),
                .o_flag   (sticky_q[g])
            );
        end else begin : g_off
            // Serial positions carry no sticky cell
            assign sticky_q[g] = 1'b0;
        end
    end

    // Serial status bits mirror buffer state
    // receive full and transmit empty, read-only
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            rx_full_q  <= 1'b0;
            tx_empty_q <= 1'b0;
        end else begin
            rx_full_q  <= i_rx_full;
            tx_empty_q <= i_tx_empty;
        end
    end

    // Flag word assembled from sticky cells and serial copies
    always_comb begin
        flags               = sticky_q;
        flags[BIT_RX_FULL]  = rx_full_q;
        flags[BIT_TX_EMPTY] = tx_empty_q;
    end

    // Enable and control registers
    // per-flag and group enables
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            peripheral_irq_enables  <= ENABLES_RST;
            global_irq_enable       <= CONTROL_RST[1];
            peripheral_group_enable <= CONTROL_RST[0];
        end else if (i_wr) begin
            if (i_addr == OFS_ENABLES) begin
                peripheral_irq_enables <= i_wdata;
            end
            if (i_addr == OFS_CONTROL) begin
                global_irq_enable       <= i_wdata[BIT_GLOBAL_EN];
                peripheral_group_enable <= i_wdata[BIT_GROUP_EN];
            end
        end
    end

    // Read data, unmapped reads zero
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_rdata <= 8'h00;
        end else if (i_rd) begin
            unique case (i_addr)
                OFS_FLAGS:   o_rdata <= flags;
                OFS_ENABLES: o_rdata <= peripheral_irq_enables;
                OFS_CONTROL: begin
                    o_rdata                <= 8'h00;
                    o_rdata[BIT_GLOBAL_EN] <= global_irq_enable;
                    o_rdata[BIT_GROUP_EN]  <= peripheral_group_enable;
                end
                default:     o_rdata <= 8'h00;
            endcase
        end else begin
            o_rdata <= 8'h00;
        end
    end

    // Gated interrupt request; stale flags fire at once when enabled
    // software clears before enabling
    assign next_irq = global_irq_enable && peripheral_group_enable
                      && |(flags & peripheral_irq_enables);

    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= next_irq;
        end
    end
endmodule : pirfb_flag_bank
`default_nettype wire

// *** common/pirfb_pkg.sv ***
// Purpose: Shared constants for the peripheral interrupt flag bank
// Assumes: Plain register port, byte-wide data
// Notes:   Offsets are register indices on the plain port
package pirfb_pkg;
    localparam int          ADDR_W          = 4;
    localparam int          DATA_W          = 8;
    // Register offsets
    localparam logic [3:0]  OFS_FLAGS       = 4'h0;
    localparam logic [3:0]  OFS_ENABLES     = 4'h1;
    localparam logic [3:0]  OFS_CONTROL     = 4'h2;
    // Flag bit positions
    localparam int          BIT_NVM_DONE    = 7;
    localparam int          BIT_CONV_DONE   = 6;
    localparam int          BIT_RX_FULL     = 5;
    localparam int          BIT_CMP_B       = 4;
    localparam int          BIT_CMP_A       = 3;
    localparam int          BIT_OSC_FAIL    = 2;
    localparam int          BIT_TX_EMPTY    = 1;
    localparam int          BIT_TIMER_B     = 0;
    // Control register bit positions
    localparam int          BIT_GLOBAL_EN   = 7;
    localparam int          BIT_GROUP_EN    = 6;
    // Software-writable flag mask and reset values
    localparam logic [7:0]  FLAGS_WR_MASK   = 8'hDD;
    localparam logic [7:0]  FLAGS_RST       = 8'h00;
    localparam logic [7:0]  ENABLES_RST     = 8'h00;
    localparam logic [1:0]  CONTROL_RST     = 2'h0;
endpackage : pirfb_pkg

// *** rtl/pirfb_sticky_flag.sv ***
// Purpose: One sticky flag, set by an event pulse, cleared by software
// Assumes: Single clock, async active-low reset
// Notes:   A set in the same cycle as a clear wins
`timescale 1ns/100ps
`default_nettype none
module pirfb_sticky_flag (
    input  wire logic i_clk,      // System clock
    input  wire logic i_arst_n,   // Async reset, active low
    input  wire logic i_set,      // Event pulse
    input  wire logic i_clr,      // Software clear
    output var  logic o_flag      // Flag state
);
    // Set has priority over clear
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_flag <= 1'b0;
        end else if (i_set) begin
            o_flag <= 1'b1;
        end else if (i_clr) begin
            o_flag <= 1'b0;
        end
    end
endmodule : pirfb_sticky_flag
`default_nettype wire

// *** test/pirfb_flag_bank_assertions.sv ***
// Purpose: Port checks for the flag bank
// Assumes: Read data one cycle late
// Notes:   Bound at the foot
`timescale 1ns/100ps
`default_nettype none
module pirfb_flag_bank_chk (
    input wire logic       i_clk,          // Clock
    input wire logic       i_arst_n,       // Reset
    input wire logic [3:0] i_addr,         // Index
    input wire logic [7:0] i_wdata,        // Data in
    input wire logic       i_wr,           // Write
    input wire logic       i_rd,           // Read
    input wire logic [7:0] o_rdata,        // Data out
    input wire logic       i_timer_b_ovf,  // Timer
    input wire logic       i_cmp_a_output, // Comparator
    input wire logic       i_rx_full,      // Receive
    input wire logic       o_irq           // Request
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_arst_n);
    // Flag register read
    sequence s_rf; i_rd && i_addr == 4'h0; endsequence
    a_rd_idle: assert property (!$past(i_rd) |-> o_rdata == 8'h00)
        else $error("data without read");
    a_bad_read: assert property ($past(i_rd) && $past(i_addr) > 4'h2 |-> o_rdata == 8'h00)
        else $error("unmapped read");
    a_timer_set: assert property (i_timer_b_ovf ##1 s_rf |=> o_rdata[0])
        else $error("timer flag");
    a_cmp_set: assert property ($changed(i_cmp_a_output) ##2 s_rf |=> o_rdata[3])
        else $error("comparator flag");
    a_rx_follow: assert property (s_rf |=> o_rdata[5] == $past(i_rx_full, 2))
        else $error("receive bit");
    a_sw_clear: assert property (i_wr && i_addr == 4'h0 && !i_wdata[0] && !i_timer_b_ovf
        ##1 !i_timer_b_ovf ##1 s_rf |=> !o_rdata[0]) else $error("flag clear");
    a_ctl_off: assert property (i_wr && i_addr == 4'h2 && !i_wdata[6] |=> ##1 !o_irq)
        else $error("group gate");
    a_en_off: assert property (i_wr && i_addr == 4'h1 && i_wdata == 8'h00 |=> ##1 !o_irq)
        else $error("enable gate");
endmodule : pirfb_flag_bank_chk
bind pirfb_flag_bank pirfb_flag_bank_chk pirfb_flag_bank_chk_inst (.i_clk(i_clk), .o_irq(o_irq),
    .i_arst_n(i_arst_n), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .i_timer_b_ovf(i_timer_b_ovf), .i_cmp_a_output(i_cmp_a_output),
    .i_rx_full(i_rx_full));
`default_nettype wire

// *** test/pirfb_periph_model.sv ***
// Purpose: Peripheral side of the flag bank
// Assumes: Requests change after an edge
// Notes:   Bits 7,6,2,0 pulse per change
`timescale 1ns/100ps
`default_nettype none
module pirfb_periph_model (
    input  wire logic       i_clk,    // Clock
    input  wire logic       i_arst_n, // Reset
    input  wire logic [7:0] i_req,    // Wanted state
    output var  logic [7:0] o_ev      // Outputs
);
    logic [7:0] last;
    // Request seen at the last edge
    always_ff @(posedge i_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            last <= 8'h00;
        end else begin
            last <= i_req;
        end
    end
    // Events pulse once; levels and comparators follow
    always_comb o_ev = (i_req & 8'h3A) | ((i_req ^ last) & 8'hC5);
endmodule : pirfb_periph_model
`default_nettype wire

// *** test/pirfb_flag_bank_tb.sv ***
// Purpose: Register bench for the flag bank
// Assumes: Model drives peripheral inputs
// Notes:   Reads checked one cycle late
`timescale 1ns/100ps
`default_nettype none
module pirfb_flag_bank_tb;
    import pirfb_pkg::*;
    logic       i_clk = 1'b0, i_arst_n = 1'b0, i_wr = 1'b0, i_rd = 1'b0, o_irq;
    logic [3:0] i_addr = 4'h0;
    logic [7:0] i_wdata = 8'h00, req = 8'h00, ev, o_rdata;
    int         err_count = 0, checked = 0;
    // Clock, 40 ns
    always #20 i_clk = ~i_clk;
    pirfb_periph_model pirfb_periph_model_inst (.i_clk(i_clk), .i_arst_n(i_arst_n),
        .i_req(req), .o_ev(ev));
    pirfb_flag_bank pirfb_flag_bank_inst (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_addr(i_addr),
        .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq),
        .i_nvm_done(ev[7]), .i_conv_done(ev[6]), .i_rx_full(ev[5]), .i_cmp_b_output(ev[4]),
        .i_cmp_a_output(ev[3]), .i_osc_fail(ev[2]), .i_tx_empty(ev[1]), .i_timer_b_ovf(ev[0]));
    task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
        checked++;
        if (s !== e) err_count++;
        if (s !== e) $display("unexpected %s expected %h seen %h", n, e, s);
    endtask : chk
    task automatic acc(input logic w, input logic [3:0] a, input logic [7:0] d);
        @(posedge i_clk);
        {i_wr, i_rd, i_addr, i_wdata} <= {w, !w, a, d};
        @(posedge i_clk);
        {i_wr, i_rd} <= 2'b00;
        if (!w) #1 chk("rdata", o_rdata, d);
    endtask : acc
    task automatic end_sim;
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : end_sim
    // Watchdog
    initial begin
        #100us err_count++;
        end_sim();
    end
    // Tests
    initial begin
        repeat (12) @(posedge i_clk);
        i_arst_n <= 1'b1;
        for (int a = 0; a < 3; a++) acc(1'b0, 4'(a), 8'h00);
        @(posedge i_clk) req <= 8'h01;
        acc(1'b0, OFS_FLAGS, 8'h01);
        @(posedge i_clk) req <= 8'hFF;
        @(posedge i_clk);
        acc(1'b0, OFS_FLAGS, 8'hFF);
        acc(1'b1, OFS_FLAGS, 8'h00);
        acc(1'b0, OFS_FLAGS, 8'h22);
        @(posedge i_clk) req <= 8'hDD;
        acc(1'b1, OFS_FLAGS, 8'hFF);
        acc(1'b0, OFS_FLAGS, 8'h00);
        acc(1'b1, OFS_ENABLES, 8'h01);
        acc(1'b1, OFS_CONTROL, 8'hFF);
        acc(1'b0, OFS_CONTROL, 8'hC0);
        @(posedge i_clk) req <= 8'hDC;
        repeat (2) @(posedge i_clk);
        #1 chk("irq", {7'h00, o_irq}, 8'h01);
        acc(1'b1, OFS_CONTROL, 8'h80);
        @(posedge i_clk) #1 chk("irq", {7'h00, o_irq}, 8'h00);
        acc(1'b1, OFS_ENABLES, 8'h00);
        acc(1'b0, 4'hF, 8'h00);
        end_sim();
    end
endmodule : pirfb_flag_bank_tb
`default_nettype wire
